// ===== inc/prot_pkg.sv
// Purpose: Shared constants for the protection supervisor
// Assumes: 125 MHz core clock
// Notes: Fault codes select what the display shows
package prot_pkg;
  localparam int unsigned CLK_HZ = 125000000;
  localparam int unsigned MEAS_W = 16;
  localparam int unsigned DELAY_W = 40;
  // Fault code shown on the display
  localparam logic [2:0] CODE_NONE = 3'h0;
  localparam logic [2:0] CODE_OV = 3'h1;
  localparam logic [2:0] CODE_OC = 3'h2;
  localparam logic [2:0] CODE_OP = 3'h3;
  localparam logic [2:0] CODE_OT = 3'h4;
  localparam logic [2:0] CODE_RV = 3'h5;
  // Over-power duration limit, in microseconds
  localparam int unsigned OP_LIMIT_US = 1000;
  localparam longint unsigned OP_LIMIT_CYC = longint'(OP_LIMIT_US) * CLK_HZ / 1000000;
  // Beep length, in microseconds
  localparam int unsigned BEEP_US = 100000;
  localparam longint unsigned BEEP_CYC = longint'(BEEP_US) * CLK_HZ / 1000000;
  localparam logic [4:0] STATUS_RESET = 5'h00;
  localparam logic SUMMARY_RESET = 1'b0;
endpackage : prot_pkg

// ===== core/dur_timer.sv
// Purpose: Duration timer that flags expiry after a programmed count
// Assumes: Count restarts whenever run drops or restart pulses
// Notes: Saturates at expiry
`timescale 1ns/10ps
module dur_timer #(
  parameter int unsigned W = 40
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic run,
  input wire logic restart,
  input wire logic [W-1:0] limit,
  output logic expired
);
  logic [W-1:0] count_r;

  always_ff @(posedge core_clk)
  begin
    if (rst || !run || restart)
    begin
      count_r <= '0;
    end
    else if (count_r < limit)
    begin
      count_r <= count_r + W'(1);
    end
  end

  assign expired = run && !restart && (count_r >= limit);
endmodule : dur_timer

// ===== core/prot_supervisor.sv
// Purpose: Latched protection supervisor for a DC electronic load
// Assumes: Fault detectors and measurements synchronous to core_clk
// Notes: Rules carried by this block follow
// Contract
// - A trip sets status, turns input off, beeps, shows code, latches out commands.
// - Latched state is left only by panel clear or remote clear.
// - A clear with the fault still present latches again at once.
// - Enabled over-current below delay shows pending, input stays on; clear restarts timer.
// - Over fixed voltage threshold trips, shows over-voltage code, sets its flags.
// - With over-current enabled, current above programmed limit starts timer and shows pending, input stays on.
// - Timer reaching delay trips, shows over-current code, sets over-current and summary.
// - Power above rating engages limiter at once while power is computed.
// - Over-power lasting beyond limit trips, shows code, sets over-power and summary.
// - Over-temperature trips; clear does not release until temperature is normal.
// - Reverse polarity trips, shows reverse code, sets reverse and voltage-fault flags.
// - Status flags stay until a clear has come and the fault is gone.
`timescale 1ns/10ps
module prot_supervisor #(
  parameter int unsigned MW = prot_pkg::MEAS_W,
  parameter int unsigned DW = prot_pkg::DELAY_W,
  parameter int unsigned POWER_MAX = 400,
  parameter int unsigned OV_THRESH = 16'h7fff,
  parameter longint unsigned OP_LIMIT = prot_pkg::OP_LIMIT_CYC,
  parameter longint unsigned BEEP_LEN = prot_pkg::BEEP_CYC
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [MW-1:0] voltage_meas,
  input wire logic [MW-1:0] current_meas,
  input wire logic temp_high,
  input wire logic reverse_detect,
  input wire logic oc_enable,
  input wire logic [MW-1:0] oc_level,
  input wire logic [DW-1:0] oc_delay,
  input wire logic panel_clear,
  input wire logic remote_clear,
  input wire logic input_on_req,
  input wire logic input_off_req,
  output logic input_on,
  output logic power_limit_on,
  output logic [2*MW-1:0] power_meas,
  output logic beep,
  output logic [2:0] fault_code,
  output logic latched,
  output logic overvoltage_flag,
  output logic overcurrent_flag,
  output logic overpower_flag,
  output logic overtemperature_flag,
  output logic reverse_polarity_flag,
  output logic voltage_fault_flag,
  output logic protection_summary_flag,
  output logic protection_pending_indicator
);
  typedef enum logic [0:0] {ST_NORMAL, ST_LATCHED} state_t;

  state_t state_r;
  logic [2*MW-1:0] power_now;
  logic ov_cond;
  logic oc_cond;
  logic op_cond;
  logic clear;
  logic oc_expired;
  logic op_expired;
  logic [4:0] trip;
  logic [4:0] cond;
  logic [4:0] status_r;
  logic [4:0] status_nxt;
  logic [31:0] beep_cnt_r;
  logic [2:0] code_nxt;

  assign power_now = voltage_meas * current_meas;
  assign clear = panel_clear || remote_clear;
  assign ov_cond = voltage_meas > MW'(OV_THRESH);
  assign oc_cond = oc_enable && (current_meas > oc_level);
  assign op_cond = power_now > (2*MW)'(POWER_MAX);

  dur_timer #(.W(DW)) u_oc_timer (
    .core_clk(core_clk),
    .rst(rst),
    .run(oc_cond),
    .restart(clear),
    .limit(oc_delay),
    .expired(oc_expired)
  );

  dur_timer #(.W(DW)) u_op_timer (
    .core_clk(core_clk),
    .rst(rst),
    .run(op_cond),
    .restart(1'b0),
    .limit(DW'(OP_LIMIT)),
    .expired(op_expired)
  );

  // Order: OV, OC, OP, OT, RV
  assign cond = {reverse_detect, temp_high, op_cond, oc_cond, ov_cond};
  assign trip = {reverse_detect, temp_high, op_expired, oc_expired, ov_cond};

  // Flags set on trip; drop only on a clear once the fault is gone
  always_comb
  begin
    status_nxt = status_r | trip;
    if (clear)
    begin
      status_nxt = trip | (status_r & cond);
    end
  end

  always_comb
  begin
    code_nxt = fault_code;
    if (trip[0])
    begin
      code_nxt = prot_pkg::CODE_OV;
    end
    else if (trip[4])
    begin
      code_nxt = prot_pkg::CODE_RV;
    end
    else if (trip[3])
    begin
      code_nxt = prot_pkg::CODE_OT;
    end
    else if (trip[2])
    begin
      code_nxt = prot_pkg::CODE_OP;
    end
    else if (trip[1])
    begin
      code_nxt = prot_pkg::CODE_OC;
    end
    else if (state_r == ST_LATCHED && clear && status_nxt == 5'h00)
    begin
      code_nxt = prot_pkg::CODE_NONE;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      status_r <= prot_pkg::STATUS_RESET;
    end
    else
    begin
      status_r <= status_nxt;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      state_r <= ST_NORMAL;
    end
    else
    begin
      unique case (state_r)
        ST_NORMAL:
        begin
          if (|trip)
          begin
            state_r <= ST_LATCHED;
          end
        end
        ST_LATCHED:
        begin
          if (clear && status_nxt == 5'h00)
          begin
            state_r <= ST_NORMAL;
          end
        end
      endcase
    end
  end

  // Input on/off commands are ignored while latched
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      input_on <= 1'b0;
    end
    else if (|trip || state_r == ST_LATCHED)
    begin
      input_on <= 1'b0;
    end
    else if (input_off_req)
    begin
      input_on <= 1'b0;
    end
    else if (input_on_req)
    begin
      input_on <= 1'b1;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      beep_cnt_r <= '0;
      beep <= 1'b0;
    end
    else if (state_r == ST_NORMAL && |trip)
    begin
      beep_cnt_r <= 32'(BEEP_LEN);
      beep <= 1'b1;
    end
    else if (beep_cnt_r != 32'h0)
    begin
      beep_cnt_r <= beep_cnt_r - 32'h1;
      beep <= beep_cnt_r > 32'h1;
    end
    else
    begin
      beep <= 1'b0;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      fault_code <= prot_pkg::CODE_NONE;
      latched <= 1'b0;
    end
    else
    begin
      fault_code <= code_nxt;
      latched <= (state_r == ST_LATCHED) ? !(clear && status_nxt == 5'h00) : |trip;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      power_limit_on <= 1'b0;
      power_meas <= '0;
    end
    else
    begin
      power_limit_on <= op_cond;
      power_meas <= power_now;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      overvoltage_flag <= 1'b0;
      overcurrent_flag <= 1'b0;
      overpower_flag <= 1'b0;
      overtemperature_flag <= 1'b0;
      reverse_polarity_flag <= 1'b0;
      voltage_fault_flag <= 1'b0;
      protection_summary_flag <= prot_pkg::SUMMARY_RESET;
      protection_pending_indicator <= 1'b0;
    end
    else
    begin
      overvoltage_flag <= status_nxt[0];
      overcurrent_flag <= status_nxt[1];
      overpower_flag <= status_nxt[2];
      overtemperature_flag <= status_nxt[3];
      reverse_polarity_flag <= status_nxt[4];
      voltage_fault_flag <= status_nxt[0] | status_nxt[4];
      protection_summary_flag <= |status_nxt[3:1];
      protection_pending_indicator <= oc_cond && !oc_expired && !clear;
    end
  end
endmodule : prot_supervisor

// ===== dv/prot_properties.sv
// Purpose: Port checks of the supervisor
// Assumes: Sync reset
// Notes: Bound below
`timescale 1ns/10ps
module prot_properties #(
  parameter int unsigned MW = 16,
  parameter int unsigned POWER_MAX = 400,
  parameter int unsigned OV_THRESH = 16'h7fff
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [MW-1:0] voltage_meas,
  input wire logic [MW-1:0] current_meas,
  input wire logic temp_high,
  input wire logic reverse_detect,
  input wire logic oc_enable,
  input wire logic panel_clear,
  input wire logic remote_clear,
  input wire logic input_on,
  input wire logic [2*MW-1:0] power_meas,
  input wire logic [2:0] fault_code,
  input wire logic latched,
  input wire logic overvoltage_flag,
  input wire logic overtemperature_flag,
  input wire logic voltage_fault_flag,
  input wire logic protection_summary_flag,
  input wire logic protection_pending_indicator
);
  wire logic clr = panel_clear | remote_clear;
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (rst);
  sequence clean_clear;
    clr && !temp_high && !reverse_detect && !oc_enable && voltage_meas <= OV_THRESH
      && power_meas <= POWER_MAX && voltage_meas * current_meas <= POWER_MAX;
  endsequence
  chk_ov_trip: assert property (voltage_meas > OV_THRESH |=> overvoltage_flag
    && voltage_fault_flag && latched && fault_code == prot_pkg::CODE_OV) else $error("no ov trip");
  chk_ot_latch: assert property (temp_high |=> overtemperature_flag
    && protection_summary_flag && latched) else $error("no ot trip");
  chk_latch_hold: assert property (latched && !clr |=> latched) else $error("latch lost");
  chk_input_off: assert property (latched |-> !input_on) else $error("input on");
  chk_flag_sticky: assert property (voltage_fault_flag && !clr |=> voltage_fault_flag)
    else $error("flag dropped");
  chk_pend_off: assert property (!oc_enable |=> !protection_pending_indicator)
    else $error("pending while off");
  chk_power_calc: assert property (1'b1 |=>
    power_meas == $past(voltage_meas) * $past(current_meas)) else $error("bad power");
  chk_clear_free: assert property (latched ##0 clean_clear |=> !latched)
    else $error("clear refused");
endmodule : prot_properties
bind prot_supervisor prot_properties #(.MW(MW), .POWER_MAX(POWER_MAX), .OV_THRESH(OV_THRESH))
  chk (.core_clk, .rst, .voltage_meas, .current_meas, .temp_high, .reverse_detect, .oc_enable,
  .panel_clear, .remote_clear, .input_on, .power_meas, .fault_code, .latched, .overvoltage_flag,
  .overtemperature_flag, .voltage_fault_flag, .protection_summary_flag,
  .protection_pending_indicator);

// ===== dv/src_model.sv
// Purpose: Source under test stand-in
// Assumes: Bench picks the fault
// Notes: Levels only
`timescale 1ns/10ps
module src_model (
  input wire logic [2:0] sel,
  input wire logic [15:0] v_set,
  input wire logic [15:0] i_set,
  output logic [15:0] voltage_meas,
  output logic [15:0] current_meas,
  output logic temp_high,
  output logic reverse_detect
);
  assign voltage_meas = (sel == 3'h1) ? 16'hffff : v_set;
  assign current_meas = i_set;
  assign temp_high = sel == 3'h4;
  assign reverse_detect = sel == 3'h5;
endmodule : src_model

// ===== dv/tb_prot_supervisor.sv
// Purpose: Supervisor bench
// Assumes: Short timers
// Notes: Seeded levels
`timescale 1ns/10ps
module tb_prot_supervisor;
  logic core_clk = 1'b0, rst = 1'b1, oc_enable = 1'b0, pc = 1'b0, rc = 1'b0, req = 1'b0;
  logic off = 1'b0;
  logic [2:0] sel = 3'h0;
  logic [15:0] v_set = 16'h1, i_set = 16'h0, oc_level = 16'h0;
  logic [39:0] oc_delay = 40'ha;
  logic [2:0] codes [3] = '{3'h1, 3'h4, 3'h5};
  wire logic [15:0] voltage_meas, current_meas;
  wire logic temp_high, reverse_detect, on, pl, pend, lat, bp;
  wire logic [31:0] pm;
  wire logic [2:0] code;
  wire logic [6:0] fl;
  int error_cnt = 0, compares = 0, cyc = 0, n = 0;
  always #4 core_clk = ~core_clk;
  src_model src (.sel, .v_set, .i_set, .voltage_meas, .current_meas, .temp_high, .reverse_detect);
  prot_supervisor #(.OP_LIMIT(10), .BEEP_LEN(4)) dut (.core_clk, .rst, .voltage_meas,
    .current_meas, .temp_high, .reverse_detect, .oc_enable, .oc_level, .oc_delay,
    .panel_clear(pc), .remote_clear(rc), .input_on_req(req), .input_off_req(off), .input_on(on),
    .power_limit_on(pl), .power_meas(pm), .beep(bp), .fault_code(code), .latched(lat),
    .overvoltage_flag(fl[6]), .overcurrent_flag(fl[5]), .overpower_flag(fl[4]),
    .overtemperature_flag(fl[3]), .reverse_polarity_flag(fl[2]), .voltage_fault_flag(fl[1]),
    .protection_summary_flag(fl[0]), .protection_pending_indicator(pend));
  function automatic logic [6:0] flg(input logic [2:0] c);
    case (c)
      3'h1: return 7'h42;
      3'h2: return 7'h21;
      3'h3: return 7'h11;
      3'h4: return 7'h09;
      3'h5: return 7'h06;
      default: return 7'h00;
    endcase
  endfunction : flg
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic step(input int k);
    repeat (k) @(posedge core_clk);
  endtask : step
  task automatic end_sim;
    $display("errors %0d compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : end_sim
  task automatic clr(input logic pnl);
    pc <= pnl;
    rc <= ~pnl;
    step(1);
    pc <= 1'b0;
    rc <= 1'b0;
    step(1);
    #1;
  endtask : clr
  task automatic turn_on;
    req <= 1'b1;
    step(1);
    req <= 1'b0;
    step(1);
    #1;
    check(on, 1'b1);
  endtask : turn_on
  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc > 2000)
    begin
      error_cnt++;
      end_sim();
    end
  end
  initial
  begin
    n = $urandom(75321);
    step(12);
    rst <= 1'b0;
    step(1);
    #1;
    check({fl, lat, on, code}, 0);
    turn_on();
    for (int k = 0; k < 3; k++)
    begin
      v_set <= 16'(1 + $urandom % 100);
      i_set <= 16'($urandom % 4);
      sel <= codes[k];
      step(2);
      #1;
      check({fl, code, lat, on, bp}, {flg(codes[k]), codes[k], 3'b101});
      req <= 1'b1;
      step(1);
      req <= 1'b0;
      clr(k == 1);
      check({fl, lat, on, bp}, {flg(codes[k]), 3'b100});
      sel <= 3'h0;
      clr(k == 1);
      check({fl, lat, code}, 0);
      turn_on();
    end
    off <= 1'b1;
    req <= 1'b1;
    step(1);
    off <= 1'b0;
    req <= 1'b0;
    step(1);
    #1;
    check(on, 1'b0);
    turn_on();
    v_set <= 16'h1;
    oc_level <= 16'(100 + $urandom % 200);
    oc_enable <= 1'b1;
    step(1);
    i_set <= oc_level + 16'h1;
    step(4);
    #1;
    check({pend, on, fl}, 9'h180);
    clr(1'b0);
    for (n = 2; fl[5] !== 1'b1 && n < 30; n++)
    begin
      step(1);
      #1;
    end
    check(n >= 9 && n <= 14, 1'b1);
    check({fl, code, on}, {flg(3'h2), 4'h4});
    i_set <= 16'h0;
    clr(1'b1);
    check({fl, lat}, 0);
    repeat (2)
    begin
      i_set <= oc_level + 16'h1;
      step(7);
      i_set <= 16'h0;
      step(1);
    end
    #1;
    check({fl, pend}, 0);
    oc_enable <= 1'b0;
    i_set <= oc_level + 16'h1;
    step(20);
    #1;
    check({fl, pend}, 0);
    v_set <= 16'h14;
    i_set <= 16'h1e;
    step(3);
    #1;
    check(pm, 32'h258);
    check({pl, fl}, 8'h80);
    step(12);
    #1;
    check({fl, code}, {flg(3'h3), 3'h3});
    end_sim();
  end
endmodule : tb_prot_supervisor
